// ### rtl/prcc_pkg.sv
package prcc_pkg;
   // configuration word layout
   localparam int CFG_W          = 21;
   localparam int BIT_PAGE       = 7;
   localparam int TEMP_HI        = 6;
   localparam int TEMP_LO        = 5;
   localparam int BIT_SLEEP      = 4;
   localparam int COV_HI         = 2;
   localparam int COV_LO         = 0;
   localparam logic [CFG_W-1:0] CFG_RESET    = 21'h000070;
   localparam logic [CFG_W-1:0] CFG_KEEP     = 21'h0000f7;
   localparam logic [1:0] TEMP_85C           = 2'h3;
   localparam logic [1:0] TEMP_70C           = 2'h0;
   localparam logic [1:0] TEMP_45C           = 2'h1;
   localparam logic [1:0] TEMP_15C           = 2'h2;
   localparam logic [2:0] COV_FULL           = 3'h0;
   localparam logic [2:0] COV_NONE           = 3'h4;
   localparam int ADDR_W         = 21;
   localparam int DATA_W         = 16;
   localparam logic [ADDR_W-1:0] SW_ADDR     = 21'h1fffff;

   // timing
   localparam int  CLK_PS        = 8000;
   localparam int  STROBE_NS     = 80;
   localparam int  ZZWE_NS       = 16;
   localparam int  SLEEP_MIN_US  = 11;
   localparam int  INIT_US       = 150;
   localparam int  STROBE_CYC    = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int  ZZWE_CYC      = (ZZWE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int  SLEEP_CYC     = (SLEEP_MIN_US * 1000000 + CLK_PS - 1) / CLK_PS;
   localparam int  INIT_CYC      = (INIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
   localparam int  CNT_W         = 16;

   typedef enum logic [1:0] {
      PRCC_OP_PIN_LOAD = 2'h0,
      PRCC_OP_SW_LOAD  = 2'h1,
      PRCC_OP_SW_READ  = 2'h2,
      PRCC_OP_SLEEP    = 2'h3
   } prcc_op_t;

   typedef enum logic [3:0] {
      PRCC_IDLE   = 4'h0,
      PRCC_ZZLOW  = 4'h1,
      PRCC_STROBE = 4'h3,
      PRCC_GAP    = 4'h2,
      PRCC_SLEEP  = 4'h6,
      PRCC_WAKE   = 4'h7,
      PRCC_INIT   = 4'h5
   } prcc_state_t;

   typedef struct packed {
      logic              chip_select_n;
      logic              write_strobe_n;
      logic              output_enable_n;
      logic              sleep_pin_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe;
   } prcc_pins_t;

   function automatic logic [CFG_W-1:0] prcc_clean(input logic [CFG_W-1:0] v);
      return v & CFG_KEEP;
   endfunction
endpackage

// ### rtl/prcc_host.sv
// Behaviour
// [RULE1] host writes zero in reserved bits 20..8 and bit 3 on every load
// [RULE2] bit 7 enables page-mode reads; off after power-up
// [RULE3] bits 6..5 pick refresh temperature: 11=85,00=70,01=45,10=15
// [RULE4] bit 4 picks low-power mode: 0 deep power-down, 1 subset refresh
// [RULE5] bits 2..0: 000 whole array, 100 no array refresh
// [RULE6] other coverage codes act as whole-array refresh in the device
// [RULE7] sleep pin low enters the mode bit 4 selects
// [RULE8] software load applies subset refresh at once; sleep pin no longer starts it
// [RULE9] host changes deep power-down only through sleep-pin loads
// [RULE10] deep power-down stops refresh and loses array contents
// [RULE11] after deep power-down exit host waits 150us before accesses
// [RULE12] host picks a temperature setting at or above case temperature
// [RULE13] pin load: write right after sleep pin falls, address lines captured
// [RULE14] software sequence: two reads, two writes at top address; read-back reads fourth
// [RULE15] low-power mode needs sleep pin low over 10us; pin high exits
// [RULE16] device powers up with configuration word 0070h
// [RULE17] device ignores accesses and releases data bus during low-power modes
`timescale 1ns/1ps
`default_nettype none
module prcc_host
   import prcc_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              cmd_valid,
   input  wire prcc_op_t          cmd_op,
   input  wire logic [CFG_W-1:0]  cmd_word,
   input  wire logic              wake,
   output logic                   cmd_ready,
   output logic                   done,
   output logic [DATA_W-1:0]      read_word,
   output logic [CFG_W-1:0]       shadow_word,
   output logic                   asleep,
   output logic                   pin_load_used_sw,
   output prcc_pins_t             pins,
   input  wire logic [DATA_W-1:0] dq_in
);
   typedef struct packed {
      prcc_state_t       st;
      prcc_op_t          op;
      logic [CFG_W-1:0]  word;
      logic [CFG_W-1:0]  shadow;
      logic [1:0]        step;
      logic [CNT_W-1:0]  cnt;
      logic              sw_used;
      logic              done;
      logic [DATA_W-1:0] rd;
      logic [2:0]        sync;
      logic              wake_s;
      prcc_pins_t        p;
   } prcc_reg_t;

   prcc_reg_t r;
   prcc_reg_t next_r;

   localparam prcc_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, '0, '0, 1'b0};

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.sync = {r.sync[1:0], wake};
      if (r.sync[2] == r.sync[1]) begin
         next_r.wake_s = r.sync[2];
      end
      if (r.cnt != '0) begin
         next_r.cnt = r.cnt - 1'b1;
      end
      case (r.st)
         PRCC_IDLE: begin
            if (cmd_valid) begin
               next_r.op   = cmd_op;
               // temperature field passes as given; caller keeps it at or above case temperature
               next_r.word = prcc_clean(cmd_word);                  // [RULE1] [RULE12]
               if (cmd_op == PRCC_OP_SW_LOAD) begin
                  // software path must neither set nor clear deep power-down
                  next_r.word[BIT_SLEEP] = r.shadow[BIT_SLEEP];     // [RULE9]
               end
               next_r.step = '0;
               if (cmd_op == PRCC_OP_PIN_LOAD) begin
                  next_r.p.sleep_pin_n = 1'b0;                      // [RULE13]
                  next_r.cnt = CNT_W'(ZZWE_CYC);
                  next_r.st  = PRCC_ZZLOW;
               end else if (cmd_op == PRCC_OP_SLEEP) begin
                  next_r.p.sleep_pin_n = 1'b0;                      // [RULE7]
                  next_r.cnt = CNT_W'(SLEEP_CYC);
                  next_r.st  = PRCC_SLEEP;
               end else begin
                  next_r.st = PRCC_STROBE;
                  next_r.cnt = CNT_W'(STROBE_CYC);
                  next_r.p.addr = SW_ADDR;                          // [RULE14]
                  next_r.p.chip_select_n = 1'b0;
                  next_r.p.output_enable_n = 1'b0;
               end
            end
         end
         PRCC_ZZLOW: begin
            if (r.cnt == '0) begin
               next_r.p.addr = r.word;                              // [RULE13]
               next_r.p.chip_select_n = 1'b0;
               next_r.p.write_strobe_n = 1'b0;
               next_r.cnt = CNT_W'(STROBE_CYC);
               next_r.st = PRCC_STROBE;
            end
         end
         PRCC_STROBE: begin
            if (r.cnt == '0) begin
               // rising chip select closes the access; address and data held through the gap
               // so the device never latches a half-changed bus
               next_r.p.chip_select_n = 1'b1;
               next_r.p.write_strobe_n = 1'b1;
               next_r.p.output_enable_n = 1'b1;
               if (r.op == PRCC_OP_SW_READ && r.step == 2'h3) begin
                  next_r.rd = dq_in;                                // [RULE14]
               end
               next_r.cnt = CNT_W'(STROBE_CYC);
               next_r.st = PRCC_GAP;
            end
         end
         PRCC_GAP: begin
            if (r.cnt == '0) begin
               if (r.op == PRCC_OP_PIN_LOAD || r.step == 2'h3) begin
                  next_r.p = PINS_IDLE;
                  next_r.done = 1'b1;
                  next_r.st = PRCC_IDLE;
                  if (r.op == PRCC_OP_PIN_LOAD) begin
                     next_r.shadow = r.word;
                  end else if (r.op == PRCC_OP_SW_LOAD) begin
                     // software load takes over subset refresh control
                     next_r.shadow = r.word;                        // [RULE8]
                     next_r.sw_used = 1'b1;
                  end
               end else begin
                  next_r.step = r.step + 1'b1;
                  next_r.p.addr = SW_ADDR;                          // [RULE14]
                  next_r.p.chip_select_n = 1'b0;
                  // load writes third and fourth access; read-back writes only the third
                  if (r.step == 2'h1 || (r.step == 2'h2 && r.op == PRCC_OP_SW_LOAD)) begin // [RULE14]
                     next_r.p.write_strobe_n = 1'b0;
                     next_r.p.dq_out = r.word[DATA_W-1:0];
                     next_r.p.dq_oe = 1'b1;
                  end else begin
                     next_r.p.output_enable_n = 1'b0;
                     next_r.p.dq_oe = 1'b0;
                  end
                  next_r.cnt = CNT_W'(STROBE_CYC);
                  next_r.st = PRCC_STROBE;
               end
            end
         end
         PRCC_SLEEP: begin
            // no accesses while asleep; device would ignore them
            if (r.cnt == '0 && r.wake_s) begin                      // [RULE15] [RULE17]
               next_r.p.sleep_pin_n = 1'b1;
               next_r.st = PRCC_WAKE;
            end
         end
         PRCC_WAKE: begin
            if (!r.shadow[BIT_SLEEP]) begin
               next_r.cnt = CNT_W'(INIT_CYC);                       // [RULE11] [RULE10]
               next_r.st = PRCC_INIT;
            end else begin
               next_r.done = 1'b1;
               next_r.st = PRCC_IDLE;
            end
         end
         PRCC_INIT: begin
            if (r.cnt == '0) begin
               next_r.done = 1'b1;
               next_r.st = PRCC_IDLE;
            end
         end
         default: begin
            next_r.st = PRCC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r <= '{st: PRCC_IDLE, op: PRCC_OP_PIN_LOAD, word: '0, shadow: CFG_RESET, step: '0,
                cnt: '0, sw_used: 1'b0, done: 1'b0, rd: '0, sync: '0, wake_s: 1'b0,
                p: PINS_IDLE};                                      // [RULE16]
      end else begin
         r <= next_r;
      end
   end

   assign cmd_ready        = (r.st == PRCC_IDLE);
   assign done             = r.done;
   assign read_word        = r.rd;
   assign shadow_word      = r.shadow;
   assign asleep           = (r.st == PRCC_SLEEP);
   assign pin_load_used_sw = r.sw_used;
   assign pins             = r.p;

   property p_sleep_hold;
      @(posedge clock) disable iff (reset)
         (r.st == PRCC_IDLE && cmd_valid && cmd_op == PRCC_OP_SLEEP) |=> !pins.sleep_pin_n [*8];
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep pin released early"); // [RULE15]

   property p_reserved_zero;
      @(posedge clock) disable iff (reset)
         (r.st == PRCC_STROBE && r.op == PRCC_OP_PIN_LOAD) |-> (pins.addr & ~CFG_KEEP) == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set in load"); // [RULE1]

   property p_sw_addr;
      @(posedge clock) disable iff (reset)
         (!pins.chip_select_n && r.op inside {PRCC_OP_SW_LOAD, PRCC_OP_SW_READ}) |-> pins.addr == SW_ADDR;
   endproperty
   a_sw_addr: assert property (p_sw_addr) else $error("software access off top address"); // [RULE14]

   property p_zz_first;
      @(posedge clock) disable iff (reset)
         $fell(pins.write_strobe_n) && r.op == PRCC_OP_PIN_LOAD |-> !pins.sleep_pin_n && $past(!pins.sleep_pin_n, 2);
   endproperty
   a_zz_first: assert property (p_zz_first) else $error("pin load write before sleep pin low"); // [RULE13]

   property p_quiet_asleep;
      @(posedge clock) disable iff (reset)
         asleep |-> pins.chip_select_n && !pins.dq_oe;
   endproperty
   a_quiet_asleep: assert property (p_quiet_asleep) else $error("access while asleep"); // [RULE17]

   property p_init_wait;
      @(posedge clock) disable iff (reset)
         (r.st == PRCC_WAKE && !r.shadow[BIT_SLEEP]) |=> !cmd_ready [*8];
   endproperty
   a_init_wait: assert property (p_init_wait) else $error("ready before init wait"); // [RULE11]

   property p_sw_flag;
      @(posedge clock) disable iff (reset)
         (done && r.op == PRCC_OP_SW_LOAD && $past(r.st) == PRCC_GAP) |-> pin_load_used_sw;
   endproperty
   a_sw_flag: assert property (p_sw_flag) else $error("software load not noted"); // [RULE8]

   property p_no_dpd_sw;
      @(posedge clock) disable iff (reset)
         (done && r.op == PRCC_OP_SW_LOAD) |-> shadow_word == $past(r.word) &&
            shadow_word[BIT_SLEEP] == $past(shadow_word[BIT_SLEEP]);
   endproperty
   a_no_dpd_sw: assert property (p_no_dpd_sw) else $error("shadow not updated"); // [RULE9]
endmodule
`default_nettype wire

// ### tb/prcc_psram_model.sv
`timescale 1ns/1ps
`default_nettype none
module prcc_psram_model
   import prcc_pkg::*;
(
   input  wire prcc_pins_t   pins,
   output logic [DATA_W-1:0] dq,
   output logic [CFG_W-1:0]  cfg,
   output logic [1:0]        last_lp,
   output logic              sw_used
);
   logic [1:0]        lp = 2'h0;
   logic [3:0]        kinds = 4'h0;
   int                cnt = 0;
   logic              armed = 1'b0;
   logic              wr = 1'b0;
   logic [DATA_W-1:0] wdat = 16'h0;
   realtime           init_end = 0.0;
   realtime           fall_t = 0.0;
   initial begin
      cfg = CFG_RESET;
      last_lp = 2'h0;
      sw_used = 1'b0;
      dq = 16'h0;
   end
   wire logic full_refresh = cfg[COV_HI:COV_LO] != COV_NONE;
   // entry is judged at the rising edge from the low time, so back to back pin loads are all seen
   always @(negedge pins.sleep_pin_n) begin
      armed = 1'b1;
      fall_t = $realtime;
   end
   always @(posedge pins.sleep_pin_n) begin
      if ($realtime - fall_t > 10000.0 && !(cfg[BIT_SLEEP] && sw_used)) begin
         last_lp = cfg[BIT_SLEEP] ? 2'h1 : 2'h2;
         if (!cfg[BIT_SLEEP])
            init_end = $realtime + 150000.0;
      end
      armed = 1'b0;
      lp = 2'h0;
   end
   always @(posedge pins.chip_select_n or posedge pins.write_strobe_n)
      if (armed && !pins.sleep_pin_n) begin
         cfg = pins.addr;
         armed = 1'b0;
      end
   always @(negedge pins.write_strobe_n) begin
      wr = 1'b1;
      wdat = pins.dq_out;
   end
   always @(posedge pins.chip_select_n) begin
      if (pins.sleep_pin_n && lp == 2'h0 && $realtime >= init_end) begin
         if (pins.addr != SW_ADDR)
            cnt = 0;
         else begin
            kinds = {kinds[2:0], wr};
            cnt = cnt + 1;
            if (cnt == 4 && kinds == 4'h3) begin
               cfg = {5'h0, wdat};
               sw_used = 1'b1;
               if (cfg[BIT_SLEEP]) begin
                  lp = 2'h1;
                  last_lp = lp;
               end
            end
            if (cnt == 4)
               cnt = 0;
         end
      end
      wr = 1'b0;
   end
   // a released bus must not keep showing the last word
   always @(pins.chip_select_n or pins.output_enable_n or cnt)
      if (!pins.chip_select_n && !pins.output_enable_n && lp == 2'h0)
         dq = (cnt == 3 && kinds[2:0] == 3'h1) ? cfg[DATA_W-1:0] : 16'h5a5a;
      else
         dq = ~dq;
endmodule
`default_nettype wire

// ### tb/prcc_host_test.sv
`timescale 1ns/1ps
`default_nettype none
module prcc_host_test;
   import prcc_pkg::*;
   logic              clock = 1'b0;
   logic              reset = 1'b1;
   logic              cmd_valid = 1'b0;
   prcc_op_t          cmd_op = PRCC_OP_PIN_LOAD;
   logic [CFG_W-1:0]  cmd_word = 21'h0;
   logic              wake = 1'b0;
   logic              cmd_ready, done, asleep, pin_load_used_sw, sw_used;
   logic [DATA_W-1:0] read_word, dq;
   logic [CFG_W-1:0]  shadow_word, cfg;
   logic [1:0]        last_lp;
   prcc_pins_t        pins;
   int                n_errors = 0;
   int                comparisons = 0;
   localparam logic [1:0] TEMPS [4] = '{TEMP_85C, TEMP_70C, TEMP_45C, TEMP_15C};
   prcc_host dut_u (.clock, .reset, .cmd_valid, .cmd_op, .cmd_word, .wake, .cmd_ready, .done,
      .read_word, .shadow_word, .asleep, .pin_load_used_sw, .pins, .dq_in(dq));
   prcc_psram_model mdl_u (.pins, .dq, .cfg, .last_lp, .sw_used);
   initial begin
      forever #4 clock = ~clock;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // caller sits just after an edge, so back to back issue lands on the done cycle
   task automatic run(input prcc_op_t op, input logic [CFG_W-1:0] w);
      cmd_op = op;
      cmd_word = w;
      cmd_valid = 1'b1;
      @(posedge clock);
      #1 cmd_valid = 1'b0;
      for (int k = 0; k < 25000; k++) begin
         @(posedge clock);
         #1;
         if (done === 1'b1)
            return;
      end
      check("done", 1, 0);
   endtask
   task automatic stop_test();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock);
      #1 reset = 1'b0;
      check("shadow", CFG_RESET, shadow_word);
      check("device word", CFG_RESET, cfg);
      wake = 1'b1;
      run(PRCC_OP_SLEEP, 21'h0);
      check("mode", 1, last_lp);
      for (int i = 0; i < 5; i++) begin
         run(PRCC_OP_PIN_LOAD, {13'h1fff, i[0], TEMPS[i[1:0]], 2'h3, i[2:0]});
         check("device word", {13'h0, i[0], TEMPS[i[1:0]], 2'h2, i[2:0]}, cfg);
         check("shadow", {13'h0, i[0], TEMPS[i[1:0]], 2'h2, i[2:0]}, shadow_word);
         check("coverage", i[2:0] != 3'h4, mdl_u.full_refresh);
      end
      check("mode", 1, last_lp);
      run(PRCC_OP_PIN_LOAD, 21'h000060);
      run(PRCC_OP_SLEEP, 21'h0);
      check("mode", 2, last_lp);
      check("recovery", 1, $realtime >= mdl_u.init_end);
      run(PRCC_OP_PIN_LOAD, 21'h000070);
      run(PRCC_OP_SW_READ, 21'h0);
      check("read back", 16'h0070, read_word);
      check("sw flag", 0, pin_load_used_sw);
      run(PRCC_OP_SW_LOAD, 21'h1000a5);
      check("device word", 21'h0000b5, cfg);
      check("shadow", 21'h0000b5, shadow_word);
      check("sw flag", 1, pin_load_used_sw);
      check("mode", 1, last_lp);
      stop_test();
   end
   initial begin
      #400000;
      check("watchdog", 0, 1);
      stop_test();
   end
endmodule
`default_nettype wire
